/* File: include/eps_map.vh */
// register map, field positions, reset values and timing counts of the packet framer
`ifndef EPS_MAP_VH
`define EPS_MAP_VH

// register byte offsets (low 12 address bits decoded)
`define EPS_OFF_CTRL 12'h000
`define EPS_OFF_HDR 12'h004
`define EPS_OFF_TRAIN_LO 12'h008
`define EPS_OFF_TRAIN_HI 12'h00C
`define EPS_OFF_STATUS 12'h010

// control register fields
`define EPS_CTRL_LSB_FIRST 0
`define EPS_CTRL_PD_STANDBY 1
`define EPS_CTRL_OUT_DIS 2
`define EPS_CTRL_MODE_GLOBAL 3
`define EPS_CTRL_W 4

// status register fields
`define EPS_ST_MODE_LSB 0
`define EPS_ST_SYNCED_LSB 4
`define EPS_ST_STANDBY 8
`define EPS_ST_PDOWN 9

// reset values
`define EPS_CTRL_RST 4'h0
`define EPS_HDR_RST 8'h00
`define EPS_TRAIN_LO_RST 32'hF0F0_F0F0
`define EPS_TRAIN_HI_RST 32'hF0F0_F0F0

// packet geometry and timing
`define EPS_PKT_BITS 64
`define EPS_SAMPLE_W 12
`define EPS_HDR_W 8
`define EPS_BITS_PER_ENC 16
`define EPS_NLANES 4

// pseudorandom filler, 9-bit sequence
`define EPS_PRBS_SEED 9'h0DF

`endif

/* File: src/eps_sync_in.v */
// three-stage synchroniser for pin inputs; a change counts once stages two and three agree
`timescale 1ns/1ps
module eps_sync_in #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // raw pins and settled levels
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
      pin_out <= {WIDTH{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // bits where the last two stages disagree keep their old value
      pin_out <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_out);
    end
  end

endmodule

/* File: src/eps_ecc_enc.v */
// hamming encoder: builds one 64-bit packet from header and four samples
`timescale 1ns/1ps
`include "eps_map.vh"
module eps_ecc_enc (
  // packet content
  input wire [7:0] hdr,
  input wire [11:0] sample_1,
  input wire [11:0] sample_2,
  input wire [11:0] sample_3,
  input wire [11:0] sample_4,
  // encoded packet, bit 63 is the header msb
  output wire [63:0] pkt
);

  // template bit b sits at position n = b + 1; check bit k covers n with bit k-1 set
  function check_bit;
    input [63:0] t;
    input integer k;
    integer b;
    reg acc;
    begin
      acc = 1'b0;
      for (b = 0; b < `EPS_PKT_BITS; b = b + 1) begin
        if ((((b + 1) >> (k - 1)) & 1) == 1)
          acc = acc ^ t[b];
      end
      check_bit = acc;
    end
  endfunction

  // interleaved template with every check slot zero
  wire [63:0] tmpl;
  assign tmpl = {1'b0, hdr, sample_1, sample_2[11:1], 1'b0, sample_2[0], sample_3,
                 sample_4[11:10], 1'b0, sample_4[9:3], 1'b0, sample_4[2:0], 1'b0,
                 1'b0, 1'b0, 1'b0};

  wire check_bit_1;
  wire check_bit_2;
  wire check_bit_3;
  wire check_bit_4;
  wire check_bit_5;
  wire check_bit_6;
  wire packet_parity_bit;
  wire ecc_msb_zero;
  wire [7:0] ecc;

  assign check_bit_1 = check_bit(tmpl, 1);
  assign check_bit_2 = check_bit(tmpl, 2);
  assign check_bit_3 = check_bit(tmpl, 3);
  assign check_bit_4 = check_bit(tmpl, 4);
  assign check_bit_5 = check_bit(tmpl, 5);
  assign check_bit_6 = check_bit(tmpl, 6);
  // even parity taken last, over everything including the six check bits
  assign packet_parity_bit = ^{hdr, sample_1, sample_2, sample_3, sample_4, check_bit_6,
                               check_bit_5, check_bit_4, check_bit_3, check_bit_2,
                               check_bit_1};
  assign ecc_msb_zero = 1'b0;
  assign ecc = {ecc_msb_zero, packet_parity_bit, check_bit_6, check_bit_5, check_bit_4,
                check_bit_3, check_bit_2, check_bit_1};
  // check bits pulled out of their slots and grouped at the tail
  assign pkt = {hdr, sample_1, sample_2, sample_3, sample_4, ecc};

endmodule

/* File: src/eps_top.v */
// serial packet framer: ahb-lite registers, per-lane ecc packets, sync training, power pins
//
// Notes on behaviour
// - 64-bit packets, lane rate sixteen encode clocks
// - ecc bits grouped after header and data
// - msb first by default, lsb first option
// - ecc msb always driven zero
// - packet parity last, even, over all
// - interleaved template order fixes check coverage
// - check bit one xor coverage set
// - check bit two xor coverage set
// - check bit three xor coverage set
// - check bit four xor coverage set
// - check bit five xor coverage set
// - check bit six xor coverage set
// - reset restores registers and reinitialises datapath
// - power-down pin high turns drivers off
// - standby remap sends pseudorandom until disabled
// - power-down release resumes, settings kept
// - mode pins default per-lane sync, pin3 lane0
// - sync low sends training word
// - training word from pattern registers
// - sync high starts samples at next boundary
// - global mode: pin0 standby, rest global sync
`timescale 1ns/1ps
`include "eps_map.vh"
module eps_top #(
  parameter NLANES = `EPS_NLANES
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // converter samples, one per lane per encode tick
  input wire [NLANES*12-1:0] sample_in,
  output wire enc_tick,
  // device pins
  input wire power_down_pin,
  input wire [NLANES-1:0] mode_pin,
  // serial lanes
  output reg [NLANES-1:0] lane_data,
  output reg [NLANES-1:0] lane_oe
);

  localparam [5:0] LAST_BIT = 6'd63;
  localparam [3:0] LAST_SUB = 4'hF;

  // ---------------- bus slave ----------------
  reg [`EPS_CTRL_W-1:0] ctrl_r;
  reg [7:0] hdr_r;
  reg [31:0] train_lo_r;
  reg [31:0] train_hi_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [11:0] addr_r;
  wire [31:0] status_w;

  wire acc_ok;
  assign acc_ok = hsel & htrans[1] & hready & (hsize == 3'b010);

  // reads take one wait so that hrdata leaves a flip-flop
  assign hreadyout = ~rd_pend_r;
  assign hresp = 1'b0;

  function [31:0] rd_value;
    input [11:0] a;
    input [`EPS_CTRL_W-1:0] c;
    input [7:0] h;
    input [31:0] tl;
    input [31:0] th;
    input [31:0] st;
    begin
      case (a)
        `EPS_OFF_CTRL: rd_value = {{(32-`EPS_CTRL_W){1'b0}}, c};
        `EPS_OFF_HDR: rd_value = {24'h00_0000, h};
        `EPS_OFF_TRAIN_LO: rd_value = tl;
        `EPS_OFF_TRAIN_HI: rd_value = th;
        `EPS_OFF_STATUS: rd_value = st;
        default: rd_value = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      if (rd_pend_r) begin
        hrdata <= rd_value(addr_r, ctrl_r, hdr_r, train_lo_r, train_hi_r, status_w);
        rd_pend_r <= 1'b0;
      end else if (acc_ok) begin
        rd_pend_r <= ~hwrite;
      end
      if (hready) begin
        wr_pend_r <= acc_ok & hwrite;
      end
      if (acc_ok) begin
        addr_r <= haddr[11:0];
      end
    end
  end

  // every register returns to its default on reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `EPS_CTRL_RST;
      hdr_r <= `EPS_HDR_RST;
      train_lo_r <= `EPS_TRAIN_LO_RST;
      train_hi_r <= `EPS_TRAIN_HI_RST;
    end else if (wr_pend_r) begin
      case (addr_r)
        `EPS_OFF_CTRL: ctrl_r <= hwdata[`EPS_CTRL_W-1:0];
        `EPS_OFF_HDR: hdr_r <= hwdata[7:0];
        `EPS_OFF_TRAIN_LO: train_lo_r <= hwdata;
        `EPS_OFF_TRAIN_HI: train_hi_r <= hwdata;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  wire lsb_first;
  wire pd_standby;
  wire out_dis;
  wire mode_global;
  assign lsb_first = ctrl_r[`EPS_CTRL_LSB_FIRST];
  assign pd_standby = ctrl_r[`EPS_CTRL_PD_STANDBY];
  assign out_dis = ctrl_r[`EPS_CTRL_OUT_DIS];
  assign mode_global = ctrl_r[`EPS_CTRL_MODE_GLOBAL];

  // ---------------- pins ----------------
  wire power_down_pin_s;
  wire [NLANES-1:0] mode_s;

  eps_sync_in #(
    .WIDTH(1)
  ) u_sync_pd (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(power_down_pin),
    .pin_out(power_down_pin_s)
  );

  // mode pins settle low after reset, so every lane starts in training
  eps_sync_in #(
    .WIDTH(NLANES)
  ) u_sync_mode (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(mode_pin),
    .pin_out(mode_s)
  );

  wire pd_active;
  wire standby;
  wire global_sync;
  assign pd_active = power_down_pin_s & ~pd_standby;
  // remapped pin or global-mode standby pin both put all lanes in standby
  assign standby = (power_down_pin_s & pd_standby) | (mode_global & mode_s[0]);
  assign global_sync = &mode_s[NLANES-1:1];

  // ---------------- timing ----------------
  // one bit per hclk; an encode tick every sixteen bits
  reg [5:0] bit_cnt_r;
  wire pkt_end;
  assign pkt_end = (bit_cnt_r == LAST_BIT);
  assign enc_tick = (bit_cnt_r[3:0] == LAST_SUB);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_r <= 6'd0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 6'd1;
    end
  end

  // pseudorandom filler for standby, x^9 + x^5 + 1
  reg [8:0] prbs_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prbs_r <= `EPS_PRBS_SEED;
    end else begin
      prbs_r <= {prbs_r[7:0], prbs_r[8] ^ prbs_r[4]};
    end
  end

  // picks the bit that goes out first from a word
  function lead_bit;
    input [63:0] w;
    input lsb;
    begin
      lead_bit = lsb ? w[0] : w[`EPS_PKT_BITS-1];
    end
  endfunction

  wire [63:0] train_word;
  assign train_word = {train_hi_r, train_lo_r};

  reg [NLANES-1:0] synced_r;
  wire [NLANES-1:0] lane_bit;
  wire [NLANES-1:0] lane_sync;

  // ---------------- lanes ----------------
  genvar gi;
  generate
    for (gi = 0; gi < NLANES; gi = gi + 1) begin : g_lane
      reg [11:0] cap0_r;
      reg [11:0] cap1_r;
      reg [11:0] cap2_r;
      reg [63:0] sh_r;
      reg [63:0] sh_nxt;
      wire [63:0] pkt;
      wire [11:0] smp;

      assign smp = sample_in[gi*12 +: 12];
      // lane 0 is channel a and listens to the highest mode pin
      assign lane_sync[gi] = mode_global ? global_sync : mode_s[NLANES-1-gi];

      // the fourth sample goes straight in at the packet's last bit
      eps_ecc_enc u_enc (
        .hdr(hdr_r),
        .sample_1(cap0_r),
        .sample_2(cap1_r),
        .sample_3(cap2_r),
        .sample_4(smp),
        .pkt(pkt)
      );

      always @* begin
        sh_nxt = sh_r;
        if (pkt_end) begin
          // decided only at a packet boundary so no packet is cut
          sh_nxt = lane_sync[gi] ? pkt : train_word;
        end else if (lsb_first) begin
          sh_nxt = {1'b0, sh_r[63:1]};
        end else begin
          sh_nxt = {sh_r[62:0], 1'b0};
        end
      end

      assign lane_bit[gi] = lead_bit(sh_nxt, lsb_first);

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cap0_r <= 12'h000;
          cap1_r <= 12'h000;
          cap2_r <= 12'h000;
          sh_r <= 64'h0000_0000_0000_0000;
        end else begin
          if (enc_tick && bit_cnt_r[5:4] == 2'd0) begin
            cap0_r <= smp;
          end
          if (enc_tick && bit_cnt_r[5:4] == 2'd1) begin
            cap1_r <= smp;
          end
          if (enc_tick && bit_cnt_r[5:4] == 2'd2) begin
            cap2_r <= smp;
          end
          sh_r <= sh_nxt;
        end
      end
    end
  endgenerate

  // lane state follows its sync at each packet boundary; reset forces retraining
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      synced_r <= {NLANES{1'b0}};
    end else if (pkt_end) begin
      synced_r <= lane_sync;
    end
  end

  // drivers and data; settings survive power-down untouched
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lane_data <= {NLANES{1'b0}};
      lane_oe <= {NLANES{1'b0}};
    end else if (pd_active) begin
      lane_data <= {NLANES{1'b0}};
      lane_oe <= {NLANES{1'b0}};
    end else if (standby) begin
      lane_data <= {NLANES{prbs_r[8]}};
      lane_oe <= {NLANES{~out_dis}};
    end else begin
      lane_data <= lane_bit;
      lane_oe <= {NLANES{~out_dis}};
    end
  end

  assign status_w = {22'h00_0000, pd_active, standby, synced_r, mode_s};

endmodule

/* File: bench/eps_top_props.sv */
// checker of the framer ports: bus wait, encode tick, lane driver states
`timescale 1ns/1ps
module eps_top_props #(
  parameter NLANES = 4
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  // framer pins
  input wire enc_tick,
  input wire power_down_pin,
  input wire [NLANES-1:0] lane_data,
  input wire [NLANES-1:0] lane_oe
);
  // shadow of the control word, rebuilt from bus writes seen at the ports
  reg wr_ctl_r;
  reg [3:0] ctl_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl_r <= 1'b0;
      ctl_r <= 4'h0;
    end else if (hready) begin
      if (wr_ctl_r)
        ctl_r <= hwdata[3:0];
      wr_ctl_r <= hsel && htrans[1] && hwrite && hsize == 3'h2 && haddr[11:0] == 12'h000;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_tick_period:
    assert property (enc_tick |=> (!enc_tick)[*8] ##1 (!enc_tick)[*7] ##1 enc_tick)
    else $error("enc_tick period wrong");
  a_tick_first:
    assert property ($rose(hresetn) |-> !enc_tick ##15 enc_tick)
    else $error("first enc_tick misplaced");
  a_reset_quiet:
    assert property ($rose(hresetn) |-> lane_oe == 0 && lane_data == 0 && hrdata == 0)
    else $error("outputs not cleared by reset");
  a_read_wait:
    assert property (hsel && htrans[1] && !hwrite && hready && hsize == 3'h2
      |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_pdown_off:
    assert property (power_down_pin[*7] ##0 !ctl_r[1] |-> lane_oe == 0 && lane_data == 0)
    else $error("lanes driven in power-down");
  a_standby_drive:
    assert property (power_down_pin[*7] ##0 ctl_r[1] && $stable(ctl_r)
      |-> lane_oe == {NLANES{!ctl_r[2]}})
    else $error("standby drivers wrong");
  a_resume_drive:
    assert property ((!power_down_pin)[*7] ##0 ctl_r[3:2] == 2'h0 && $stable(ctl_r)
      |-> lane_oe == {NLANES{1'b1}})
    else $error("lanes not driven after power-down");
  a_outdis_off:
    assert property (ctl_r[2] && $stable(ctl_r) |-> lane_oe == 0)
    else $error("lanes driven while disabled");
  c_pdown: cover property (power_down_pin[*7] ##0 !ctl_r[1]);
  c_standby: cover property (power_down_pin[*7] ##0 ctl_r[1]);
  c_rereset: cover property ($rose(hresetn));
endmodule

bind eps_top eps_top_props #(.NLANES(NLANES)) eps_top_props_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .enc_tick,
  .power_down_pin, .lane_data, .lane_oe);

/* File: bench/eps_rx_model.sv */
// receiver model: deserialises each lane per packet, raises sync after training
`timescale 1ns/1ps
module eps_rx_model #(
  parameter NLANES = 4
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // lanes and sync pins
  input wire [NLANES-1:0] lane_data,
  output reg [NLANES-1:0] mode_pin,
  // bench side
  input wire [63:0] train,
  input wire [NLANES-1:0] lane_en,
  output reg [5:0] cnt,
  output reg [NLANES-1:0][63:0] word
);
  reg [NLANES-1:0][63:0] sh;
  reg lock;
  integer i;
  // cnt tracks the framer's packet counter from reset, so no hunting is needed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 6'h00;
      lock <= 1'b0;
      mode_pin <= {NLANES{1'b0}};
      sh <= '0;
      word <= '0;
    end else begin
      cnt <= cnt + 6'h01;
      for (i = 0; i < NLANES; i = i + 1) begin
        sh[i] <= {sh[i][62:0], lane_data[i]};
        if (cnt == 6'h3F)
          word[i] <= {sh[i][62:0], lane_data[i]};
        mode_pin[NLANES-1-i] <= lock & lane_en[i];
      end
      if (cnt == 6'h3F && {sh[0][62:0], lane_data[0]} == train)
        lock <= 1'b1;
    end
  end
endmodule

/* File: bench/tb_ecc_packet_sync.sv */
// testbench of the packet framer: bus tasks, lane packet checks, power pins
`timescale 1ns/1ps
`include "eps_map.vh"
module tb_ecc_packet_sync;
  localparam NL = 4;
  reg hclk, hresetn, hsel, hwrite, power_down_pin;
  reg [31:0] haddr, hwdata, d;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [7:0] pat, hdr;
  reg [63:0] train;
  reg [NL-1:0] lane_en;
  wire hready, hreadyout, hresp, enc_tick;
  wire [31:0] hrdata;
  wire [NL-1:0] mode_pin, lane_data, lane_oe;
  wire [5:0] cnt;
  wire [NL-1:0][63:0] word;
  wire [NL*12-1:0] sample_in;
  integer err_count, comparisons, i, p;
  assign hready = hreadyout;
  function [11:0] smp(input integer ln, input integer s);
    smp = 12'(pat * (ln * 4 + s + 1)) ^ 12'hA5C;
  endfunction
  genvar g;
  for (g = 0; g < NL; g = g + 1) begin : gs
    assign sample_in[g*12+:12] = smp(g, cnt[5:4]);
  end
  function [63:0] ecc_pkt(input [7:0] h, input [11:0] a, b, c, e);
    reg [63:0] t;
    reg [6:1] ck;
    integer n, k;
    begin
      t = {1'b0, h, a, b[11:1], 1'b0, b[0], c, e[11:10], 1'b0, e[9:3], 1'b0, e[2:0], 4'h0};
      ck = 6'h00;
      for (k = 1; k < 7; k = k + 1)
        for (n = 1; n < 65; n = n + 1)
          if (n[k-1])
            ck[k] = ck[k] ^ t[n-1];
      ecc_pkt = {h, a, b, c, e, 2'h0, ck};
      ecc_pkt[6] = ^ecc_pkt;
    end
  endfunction
  eps_top eps_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in),
    .enc_tick(enc_tick), .power_down_pin(power_down_pin), .mode_pin(mode_pin),
    .lane_data(lane_data), .lane_oe(lane_oe));
  eps_rx_model eps_rx_model_inst (.hclk(hclk), .hresetn(hresetn), .lane_data(lane_data),
    .mode_pin(mode_pin), .train(train), .lane_en(lane_en), .cnt(cnt), .word(word));
  // waits out the slave, keeping read data seen in the ready cycle
  task wt;
    begin
      do
        @(negedge hclk);
      while (hreadyout !== 1'b1);
      d = hrdata;
      @(posedge hclk);
    end
  endtask
  task ap(input [11:0] a, input w);
    begin
      haddr <= {20'h0_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wt;
      htrans <= 2'h0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    begin
      ap(a, 1'b1);
      hwdata <= v;
      wt;
    end
  endtask
  task chk(input [63:0] seen, input [63:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rchk(input [11:0] a, input [31:0] exp, input string what);
    begin
      ap(a, 1'b0);
      wt;
      chk({32'h0000_0000, d}, {32'h0000_0000, exp}, what);
    end
  endtask
  task pk(input integer n);
    repeat (n) begin
      do
        @(posedge hclk);
      while (cnt !== 6'h3F);
      @(posedge hclk);
    end
  endtask
  task lanes(input lsb);
    reg [63:0] e;
    for (i = 0; i < NL; i = i + 1) begin
      e = ecc_pkt(hdr, smp(i, 0), smp(i, 1), smp(i, 2), smp(i, 3));
      if (lsb)
        e = {<<{e}};
      chk(word[i], e, "lane packet");
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    #400000;
    err_count = err_count + 1;
    end_of_test;
  end
  initial begin
    err_count = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    power_down_pin = 1'b0;
    pat = 8'h00;
    hdr = 8'h5C;
    lane_en = 4'h0;
    train = 64'hF0F0_F0F0_F0F0_F0F0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`EPS_OFF_CTRL, 32'h0000_0000, "ctrl");
    rchk(`EPS_OFF_HDR, 32'h0000_0000, "hdr");
    rchk(`EPS_OFF_TRAIN_LO, 32'hF0F0_F0F0, "train_lo");
    rchk(`EPS_OFF_TRAIN_HI, 32'hF0F0_F0F0, "train_hi");
    rchk(12'h020, 32'h0000_0000, "unmapped");
    pk(2);
    for (i = 0; i < NL; i = i + 1)
      chk(word[i], train, "default training");
    wr(`EPS_OFF_TRAIN_LO, 32'h5A69_E187);
    wr(`EPS_OFF_TRAIN_HI, 32'hC3A5_0F96);
    wr(`EPS_OFF_HDR, {24'h00_0000, hdr});
    rchk(`EPS_OFF_TRAIN_HI, 32'hC3A5_0F96, "train_hi");
    train <= 64'hC3A5_0F96_5A69_E187;
    pk(2);
    for (i = 0; i < NL; i = i + 1)
      chk(word[i], train, "user training");
    lane_en <= 4'h1;
    pk(3);
    chk(word[0], ecc_pkt(hdr, smp(0, 0), smp(0, 1), smp(0, 2), smp(0, 3)), "lane0");
    chk(word[3], train, "lane3 training");
    lane_en <= 4'hF;
    for (p = 0; p < 3; p = p + 1) begin
      pat <= 8'hFF - p * 8'h55;
      pk(3);
      lanes(1'b0);
    end
    wr(`EPS_OFF_CTRL, 32'h0000_0001);
    pk(3);
    lanes(1'b1);
    // global sync: mode_pin[0] stays low so no standby, lane 3 follows the others
    wr(`EPS_OFF_CTRL, 32'h0000_0008);
    lane_en <= 4'h7;
    pk(3);
    lanes(1'b0);
    wr(`EPS_OFF_CTRL, 32'h0000_0000);
    lane_en <= 4'hF;
    power_down_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({lane_oe, lane_data}, 0, "power-down lanes");
    power_down_pin <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(lane_oe, 4'hF, "resumed oe");
    wr(`EPS_OFF_CTRL, 32'h0000_0002);
    power_down_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(lane_oe, 4'hF, "standby oe");
    wr(`EPS_OFF_CTRL, 32'h0000_0006);
    repeat (3) @(posedge hclk);
    chk(lane_oe, 4'h0, "disabled oe");
    power_down_pin <= 1'b0;
    repeat (10) @(posedge hclk);
    rchk(`EPS_OFF_CTRL, 32'h0000_0006, "ctrl kept");
    wr(`EPS_OFF_CTRL, 32'h0000_0000);
    pk(3);
    lanes(1'b0);
    rchk(`EPS_OFF_STATUS, 32'h0000_00FF, "status");
    chk({63'h0, hresp}, 64'h0, "hresp");
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`EPS_OFF_HDR, 32'h0000_0000, "hdr after reset");
    pk(2);
    chk(word[0], 64'hF0F0_F0F0_F0F0_F0F0, "training after reset");
    end_of_test;
  end
endmodule
